// *** rtl/peak_status_pkg.sv ***
/*
 * Constants for the peak capture and first event status register group:
 * register offsets, field positions, status bit positions and reset values.
 * Assumes a 16-bit register address compared against the printed offsets.
 */
package peak_status_pkg;

    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [15:0] CURRENT_PEAK_CAPTURE_OFS = 16'hE500;
    localparam logic [15:0] VOLTAGE_PEAK_CAPTURE_OFS = 16'hE501;
    localparam logic [15:0] EVENT_STATUS_FIRST_OFS   = 16'hE502;
    localparam logic [15:0] POWER_SIGN_REGISTER_OFS  = 16'hE617;
    localparam logic [15:0] EVENT_CONTROL_OFS        = 16'hE5F0;

    // ----------------------------------------------------------------
    // peak register fields
    // ----------------------------------------------------------------
    localparam int MAG_W      = 24;
    localparam int PHASE_LSB  = 24;
    localparam int PHASE_W    = 3;
    localparam int PAD_W      = 8;
    localparam int TOP_ZERO_W = 5;

    // ----------------------------------------------------------------
    // event status bit positions
    // ----------------------------------------------------------------
    localparam int STATUS_W           = 19;
    localparam int ST_TOTAL_ACTIVE    = 0;
    localparam int ST_FUND_ACTIVE     = 1;
    localparam int ST_TOTAL_REACTIVE  = 2;
    localparam int ST_FUND_REACTIVE   = 3;
    localparam int ST_APPARENT        = 4;
    localparam int ST_LINE_CYCLE      = 5;
    localparam int ST_ACT_SIGN_LSB    = 6;
    localparam int ST_SUM1_SIGN       = 9;
    localparam int ST_REACT_SIGN_LSB  = 10;
    localparam int ST_SUM2_SIGN       = 13;
    localparam int ST_PULSE_LSB       = 14;
    localparam int ST_DSP_DONE        = 17;
    localparam int ST_SUM3_SIGN       = 18;

    // ----------------------------------------------------------------
    // power sign register bit positions
    // ----------------------------------------------------------------
    localparam int SIGN_W            = 9;
    localparam int SG_ACT_LSB        = 0;
    localparam int SG_SUM1           = 3;
    localparam int SG_REACT_LSB      = 4;
    localparam int SG_SUM2           = 7;
    localparam int SG_SUM3           = 8;

    // ----------------------------------------------------------------
    // event control register fields
    // ----------------------------------------------------------------
    localparam int CTRL_W            = 6;
    localparam int CT_ACT_SEL        = 0;
    localparam int CT_REACT_SEL      = 1;
    localparam int CT_LINE_MODE      = 2;
    localparam int CT_PULSE_DIS_LSB  = 3;

    localparam logic [CTRL_W-1:0]   CTRL_RESET   = 6'h00;
    localparam logic [STATUS_W-1:0] STATUS_RESET = 19'h00000;
    localparam logic [31:0]         ZERO_WORD    = 32'h00000000;

endpackage

// *** rtl/peak_and_event_status_regs.sv ***
/*
 * Peak capture registers (current and voltage) and the first event status
 * register, with the power sign register and a small event control register.
 * Assumes the measurement datapath delivers energy bit 30 levels, power signs,
 * raw pulse levels and one-cycle done/strobe pulses synchronous to ref_clk.
 */
// Functional notes
// RQ1: current peak magnitude is held in bits 23:0 of the current peak register.
// RQ2: bits 24..26 mark which phase current (A, B, C) made the current peak.
// RQ3: bits 31:27 of both peak registers always read as zero.
// RQ4: voltage peak magnitude is held in bits 23:0 of the voltage peak register.
// RQ5: bits 24..26 mark which phase voltage (A, B, C) made the voltage peak.
// RQ6: status bit 0 sets when bit 30 of any total active accumulator toggles.
// RQ7: status bit 1 sets on fundamental active bit 30 toggle; zero without fundamental.
// RQ8: status bit 2 sets on total reactive bit 30 toggle; zero without reactive.
// RQ9: status bit 3 sets on fundamental reactive bit 30 toggle; zero without fundamental.
// RQ10: status bit 4 sets when bit 30 of any apparent accumulator toggles.
// RQ11: status bit 5 sets at end of line-cycle integration in line-cycle mode.
// RQ12: bits 6..8 flag selected active power sign change; sign in bits 0..2.
// RQ13: bits 10..12 flag selected reactive sign change; sign in bits 4..6.
// RQ14: bits 9, 13, 18 flag summed datapath sign change; sign in 3, 7, 8.
// RQ15: bits 14..16 set on a falling edge of pulse output 1..3.
// RQ16: pulse flags set even while that pulse output is disabled.
// RQ17: status bit 17 sets each time the periodic DSP computations finish.
// RQ18: status bits 31:19 always read as zero.
// RQ19: 24-bit fields go out as 32-bit words, upper 8 bits zero padded.
// RQ20: status flags stay set until software clears them; a new event wins.
`timescale 1ns/1ps

module peak_and_event_status_regs
    import peak_status_pkg::*;
#(
    parameter bit HAS_FUND     = 1'b1,
    parameter bit HAS_REACTIVE = 1'b1
) (
    input  wire logic              ref_clk,
    input  wire logic              nrst,
    input  wire logic [15:0]       reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [31:0]       reg_rdata,
    input  wire logic              current_peak_strobe,
    input  wire logic [MAG_W-1:0]  current_peak_magnitude,
    input  wire logic [2:0]        current_peak_phase_origin,
    input  wire logic              voltage_peak_strobe,
    input  wire logic [MAG_W-1:0]  voltage_peak_magnitude,
    input  wire logic [2:0]        voltage_peak_phase_origin,
    input  wire logic [2:0]        total_active_bit30,
    input  wire logic [2:0]        fund_active_bit30,
    input  wire logic [2:0]        total_reactive_bit30,
    input  wire logic [2:0]        fund_reactive_bit30,
    input  wire logic [2:0]        apparent_bit30,
    input  wire logic              line_cycle_end,
    input  wire logic [2:0]        total_active_neg,
    input  wire logic [2:0]        fund_active_neg,
    input  wire logic [2:0]        total_reactive_neg,
    input  wire logic [2:0]        fund_reactive_neg,
    input  wire logic [2:0]        sum_power_neg,
    input  wire logic [2:0]        pulse_raw_n,
    input  wire logic              dsp_cycle_end,
    output logic                   pulse_out_one,
    output logic                   pulse_out_two,
    output logic                   pulse_out_three
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [MAG_W-1:0]    ipk_mag;
        logic [PHASE_W-1:0]  ipk_ph;
        logic [MAG_W-1:0]    vpk_mag;
        logic [PHASE_W-1:0]  vpk_ph;
        logic [STATUS_W-1:0] status;
        logic [SIGN_W-1:0]   sign;
        logic [14:0]         e30_prev;
        logic [2:0]          pulse_prev;
        logic [2:0]          pulse_pin;
        logic [CTRL_W-1:0]   ctrl;
        logic                primed;
        logic [31:0]         rdata;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic [14:0]         e30_now;
    logic [14:0]         e30_chg;
    logic [2:0]          act_sel;
    logic [2:0]          react_sel;
    logic [SIGN_W-1:0]   sign_now;
    logic [SIGN_W-1:0]   sign_chg;
    logic [2:0]          pulse_fall;
    logic [STATUS_W-1:0] ev_set;
    logic [STATUS_W-1:0] wr_clr;

    // zero-pad a 24-bit field to a bus word
    function automatic logic [31:0] pad_word(input logic [MAG_W-1:0] v);
        pad_word = {{PAD_W{1'b0}}, v};
    endfunction

    // ----------------------------------------------------------------
    // event detection
    // ----------------------------------------------------------------
    // missing variants tie their bit 30 sources low, so those toggle flags never set
    assign e30_now = {apparent_bit30,
                      HAS_FUND ? fund_reactive_bit30 : 3'h0,
                      HAS_REACTIVE ? total_reactive_bit30 : 3'h0,
                      HAS_FUND ? fund_active_bit30 : 3'h0,
                      total_active_bit30};
    // first cycle after reset only learns levels, no false toggle
    assign e30_chg   = s_q.primed ? (e30_now ^ s_q.e30_prev) : 15'h0000;
    assign act_sel   = s_q.ctrl[CT_ACT_SEL] ? fund_active_neg : total_active_neg;
    assign react_sel = !HAS_REACTIVE ? 3'h0 :
                       (s_q.ctrl[CT_REACT_SEL] ? fund_reactive_neg : total_reactive_neg);
    assign sign_now  = {sum_power_neg[2], sum_power_neg[1], react_sel, sum_power_neg[0], act_sel};
    assign sign_chg  = s_q.primed ? (sign_now ^ s_q.sign) : 9'h000;
    // falling edge of the raw pulse, ahead of the disable gate
    assign pulse_fall = s_q.pulse_prev & ~pulse_raw_n;                          // RQ16

    always_comb begin
        ev_set = STATUS_RESET;
        ev_set[ST_TOTAL_ACTIVE]   = |e30_chg[2:0];                              // RQ6
        ev_set[ST_FUND_ACTIVE]    = |e30_chg[5:3];                              // RQ7
        ev_set[ST_TOTAL_REACTIVE] = |e30_chg[8:6];                              // RQ8
        ev_set[ST_FUND_REACTIVE]  = |e30_chg[11:9];                             // RQ9
        ev_set[ST_APPARENT]       = |e30_chg[14:12];                            // RQ10
        ev_set[ST_LINE_CYCLE]     = line_cycle_end & s_q.ctrl[CT_LINE_MODE];    // RQ11
        ev_set[ST_ACT_SIGN_LSB +: 3]   = sign_chg[SG_ACT_LSB +: 3];             // RQ12
        ev_set[ST_REACT_SIGN_LSB +: 3] = sign_chg[SG_REACT_LSB +: 3];           // RQ13
        ev_set[ST_SUM1_SIGN]      = sign_chg[SG_SUM1];                          // RQ14
        ev_set[ST_SUM2_SIGN]      = sign_chg[SG_SUM2];                          // RQ14
        ev_set[ST_SUM3_SIGN]      = sign_chg[SG_SUM3];                          // RQ14
        ev_set[ST_PULSE_LSB +: 3] = pulse_fall;                                 // RQ15
        ev_set[ST_DSP_DONE]       = dsp_cycle_end;                              // RQ17
    end

    // write-one-to-clear; read-only peaks ignore writes
    assign wr_clr = (reg_wr && reg_addr == EVENT_STATUS_FIRST_OFS) ?
                    reg_wdata[STATUS_W-1:0] : STATUS_RESET;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.primed     = 1'b1;
        s_d.e30_prev   = e30_now;
        s_d.sign       = sign_now;                                              // RQ12 RQ13 RQ14
        s_d.pulse_prev = pulse_raw_n;
        // disabled outputs idle high; the flag still follows the raw pulse
        s_d.pulse_pin  = pulse_raw_n | s_q.ctrl[CT_PULSE_DIS_LSB +: 3];
        // set beats clear in the same cycle
        s_d.status     = (s_q.status & ~wr_clr) | ev_set;                       // RQ20
        if (current_peak_strobe) begin
            s_d.ipk_mag = current_peak_magnitude;                               // RQ1
            s_d.ipk_ph  = current_peak_phase_origin;                            // RQ2
        end
        if (voltage_peak_strobe) begin
            s_d.vpk_mag = voltage_peak_magnitude;                               // RQ4
            s_d.vpk_ph  = voltage_peak_phase_origin;                            // RQ5
        end
        if (reg_wr && reg_addr == EVENT_CONTROL_OFS) begin
            s_d.ctrl = reg_wdata[CTRL_W-1:0];
        end
        s_d.rdata = ZERO_WORD;
        if (reg_rd) begin
            case (reg_addr)
                CURRENT_PEAK_CAPTURE_OFS: begin
                    s_d.rdata = pad_word(s_q.ipk_mag);                          // RQ19
                    s_d.rdata[PHASE_LSB +: PHASE_W] = s_q.ipk_ph;               // RQ3
                end
                VOLTAGE_PEAK_CAPTURE_OFS: begin
                    s_d.rdata = pad_word(s_q.vpk_mag);                          // RQ19
                    s_d.rdata[PHASE_LSB +: PHASE_W] = s_q.vpk_ph;               // RQ3
                end
                EVENT_STATUS_FIRST_OFS: begin
                    s_d.rdata[STATUS_W-1:0] = s_q.status;                       // RQ18
                end
                POWER_SIGN_REGISTER_OFS: begin
                    s_d.rdata[SIGN_W-1:0] = s_q.sign;
                end
                EVENT_CONTROL_OFS: begin
                    s_d.rdata[CTRL_W-1:0] = s_q.ctrl;
                end
                default: begin
                    s_d.rdata = ZERO_WORD;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            s_q           <= '0;
            s_q.ctrl      <= CTRL_RESET;
            s_q.status    <= STATUS_RESET;
            s_q.pulse_prev <= 3'h7;
            s_q.pulse_pin <= 3'h7;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata       = s_q.rdata;
    assign pulse_out_one   = s_q.pulse_pin[0];
    assign pulse_out_two   = s_q.pulse_pin[1];
    assign pulse_out_three = s_q.pulse_pin[2];

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    logic past_valid_q;
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            past_valid_q <= 1'b0;
        end else begin
            past_valid_q <= 1'b1;
        end
    end

    a_current_peak_read: assert property (                                      // RQ1
        current_peak_strobe ##1 (reg_rd && reg_addr == CURRENT_PEAK_CAPTURE_OFS && !current_peak_strobe)
        |=> reg_rdata[MAG_W-1:0] == $past(current_peak_magnitude, 2)
    ) else $error("current peak magnitude not returned");

    a_current_phase_read: assert property (                                     // RQ2
        current_peak_strobe ##1 (reg_rd && reg_addr == CURRENT_PEAK_CAPTURE_OFS && !current_peak_strobe)
        |=> reg_rdata[PHASE_LSB +: PHASE_W] == $past(current_peak_phase_origin, 2)
    ) else $error("current peak phase origin not returned");

    a_voltage_peak_read: assert property (                                      // RQ4
        voltage_peak_strobe ##1 (reg_rd && reg_addr == VOLTAGE_PEAK_CAPTURE_OFS && !voltage_peak_strobe)
        |=> reg_rdata[PHASE_LSB-1:0] == $past(voltage_peak_magnitude, 2)
        && reg_rdata[PHASE_LSB +: PHASE_W] == $past(voltage_peak_phase_origin, 2)
    ) else $error("voltage peak not returned");

    a_peak_top_zero: assert property (                                          // RQ3
        reg_rd && (reg_addr == CURRENT_PEAK_CAPTURE_OFS || reg_addr == VOLTAGE_PEAK_CAPTURE_OFS)
        |=> reg_rdata[31 -: TOP_ZERO_W] == 5'h00
    ) else $error("peak register top bits not zero");

    a_status_top_zero: assert property (                                        // RQ18
        reg_rd && reg_addr == EVENT_STATUS_FIRST_OFS |=> reg_rdata[31:STATUS_W] == 13'h0000
    ) else $error("status reserved bits not zero");

    a_active_toggle_flag: assert property (                                     // RQ6
        past_valid_q && $changed(total_active_bit30) && s_q.primed |=> s_q.status[ST_TOTAL_ACTIVE]
    ) else $error("total active toggle not flagged");

    a_apparent_toggle_flag: assert property (                                   // RQ10
        past_valid_q && $changed(apparent_bit30) && s_q.primed |=> s_q.status[ST_APPARENT]
    ) else $error("apparent toggle not flagged");

    a_variant_zero_bits: assert property (                                      // RQ7
        (!HAS_FUND |-> !s_q.status[ST_FUND_ACTIVE] && !s_q.status[ST_FUND_REACTIVE])
        and (!HAS_REACTIVE |-> !s_q.status[ST_TOTAL_REACTIVE] && s_q.status[12:10] == 3'h0)
    ) else $error("absent measurement flag set");

    a_line_cycle_mode: assert property (                                        // RQ11
        line_cycle_end && s_q.ctrl[CT_LINE_MODE] |=> s_q.status[ST_LINE_CYCLE]
    ) else $error("line cycle end not flagged");

    a_line_cycle_gate: assert property (                                        // RQ11
        !s_q.status[ST_LINE_CYCLE] && !(line_cycle_end && s_q.ctrl[CT_LINE_MODE])
        |=> !s_q.status[ST_LINE_CYCLE]
    ) else $error("line cycle flag set outside mode");

    a_active_sign_flag: assert property (                                       // RQ12
        s_q.primed && act_sel != s_q.sign[SG_ACT_LSB +: 3]
        |=> (s_q.status[ST_ACT_SIGN_LSB +: 3] & $past(act_sel ^ s_q.sign[SG_ACT_LSB +: 3]))
            == $past(act_sel ^ s_q.sign[SG_ACT_LSB +: 3])
            && s_q.sign[SG_ACT_LSB +: 3] == $past(act_sel)
    ) else $error("active sign change not flagged");

    a_sum_sign_flag: assert property (                                          // RQ14
        s_q.primed && sum_power_neg[2] != s_q.sign[SG_SUM3]
        |=> s_q.status[ST_SUM3_SIGN] && s_q.sign[SG_SUM3] == $past(sum_power_neg[2])
    ) else $error("sum three sign change not flagged");

    a_pulse_fall_flag: assert property (                                        // RQ15
        $fell(pulse_raw_n[0]) && past_valid_q |=> s_q.status[ST_PULSE_LSB]
    ) else $error("pulse one fall not flagged");

    a_disabled_pin_high: assert property (                                      // RQ16
        s_q.ctrl[CT_PULSE_DIS_LSB] && $stable(s_q.ctrl) |=> pulse_out_one
    ) else $error("disabled pulse output driven low");

    a_dsp_done_flag: assert property (                                          // RQ17
        dsp_cycle_end |=> s_q.status[ST_DSP_DONE] ##1 (s_q.status[ST_DSP_DONE] || $past(wr_clr[ST_DSP_DONE]))
    ) else $error("dsp done not flagged or lost");

    a_flag_sticky: assert property (                                            // RQ20
        s_q.status[ST_APPARENT] && !wr_clr[ST_APPARENT] |=> s_q.status[ST_APPARENT]
    ) else $error("status flag dropped without clear");

    c_status_cleared: cover property (
        s_q.status[ST_DSP_DONE] ##1 !s_q.status[ST_DSP_DONE]
    );

    c_set_beats_clear: cover property (
        dsp_cycle_end && wr_clr[ST_DSP_DONE]
    );

    c_disabled_pulse_flag: cover property (
        s_q.ctrl[CT_PULSE_DIS_LSB + 1] && pulse_fall[1]
    );

endmodule

// *** bench/host_model.sv ***
/*
 * Host side of the register port: one-cycle write and read strobes.
 * Assumes tasks are entered just after a rising edge of ref_clk.
 */
`timescale 1ns/1ps

module host_model (
    input  wire logic        ref_clk,
    output logic      [15:0] reg_addr,
    output logic      [31:0] reg_wdata,
    output logic             reg_wr,
    output logic             reg_rd,
    input  wire logic [31:0] reg_rdata
);
    // ------------------------------------------------------------
    // bus cycles
    // ------------------------------------------------------------
    initial begin
        reg_addr  = 16'h0000;
        reg_wdata = 32'h00000000;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // an edge passes after the strobe drops, so the next call never re-drives it
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        @(posedge ref_clk);
    endtask

    // data stands only in the cycle after the strobe: taken at that edge
    task automatic rd(input logic [15:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
        d = reg_rdata;
    endtask
endmodule

// *** bench/peak_and_event_status_regs_tb_top.sv ***
/*
 * Self-checking bench for the peak capture and first event status registers.
 * Assumes default variant parameters (fundamental and reactive present).
 */
`timescale 1ns/1ps

module peak_and_event_status_regs_tb_top;
    import peak_status_pkg::*;

    logic ref_clk, nrst, reg_wr, reg_rd, line_cycle_end, dsp_cycle_end;
    logic current_peak_strobe, voltage_peak_strobe, pulse_out_one, pulse_out_two, pulse_out_three;
    logic [15:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, got;
    logic [23:0] current_peak_magnitude, voltage_peak_magnitude;
    logic [2:0]  current_peak_phase_origin, voltage_peak_phase_origin, total_active_bit30, fund_active_bit30;
    logic [2:0]  total_reactive_bit30, fund_reactive_bit30, apparent_bit30, total_active_neg;
    logic [2:0]  fund_active_neg, total_reactive_neg, fund_reactive_neg, sum_power_neg, pulse_raw_n;
    wire  [2:0]  pins = {pulse_out_three, pulse_out_two, pulse_out_one};
    int          errors, checked, cycles;
    // kind, lane, status bit
    int rows[21][3] = '{'{0,0,0}, '{0,2,0}, '{1,1,1}, '{2,0,2}, '{3,2,3}, '{4,1,4}, '{5,0,6},
        '{5,1,7}, '{5,2,8}, '{6,0,10}, '{6,1,11}, '{6,2,12}, '{7,0,9}, '{7,1,13}, '{7,2,18},
        '{8,0,14}, '{8,1,15}, '{8,2,16}, '{9,0,5}, '{10,0,17}, '{4,2,4}};

    peak_and_event_status_regs peak_and_event_status_regs_i (.ref_clk, .nrst, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .current_peak_strobe, .current_peak_magnitude,
        .current_peak_phase_origin, .voltage_peak_strobe, .voltage_peak_magnitude,
        .voltage_peak_phase_origin, .total_active_bit30, .fund_active_bit30, .total_reactive_bit30,
        .fund_reactive_bit30, .apparent_bit30, .line_cycle_end, .total_active_neg, .fund_active_neg,
        .total_reactive_neg, .fund_reactive_neg, .sum_power_neg, .pulse_raw_n, .dsp_cycle_end,
        .pulse_out_one, .pulse_out_two, .pulse_out_three);
    host_model host_model_i (.ref_clk, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);

    // ------------------------------------------------------------
    // clock, watchdog, report
    // ------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic results();
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // run needs well under 1000 cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            results();
        end
    end

    task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic chk_bit(input logic g, input logic e);
        chk_word({31'h00000000, g}, {31'h00000000, e});
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [31:0] e);
        host_model_i.rd(a, got);
        chk_word(got, e);
    endtask

    // one event, then one idle edge so the flag lands before the read
    task automatic apply(input int k, input int l);
        case (k)
            0: total_active_bit30[l] <= ~total_active_bit30[l];
            1: fund_active_bit30[l] <= ~fund_active_bit30[l];
            2: total_reactive_bit30[l] <= ~total_reactive_bit30[l];
            3: fund_reactive_bit30[l] <= ~fund_reactive_bit30[l];
            4: apparent_bit30[l] <= ~apparent_bit30[l];
            5: total_active_neg[l] <= ~total_active_neg[l];
            6: total_reactive_neg[l] <= ~total_reactive_neg[l];
            7: sum_power_neg[l] <= ~sum_power_neg[l];
            8: pulse_raw_n[l] <= 1'b0;
            9: line_cycle_end <= 1'b1;
            default: dsp_cycle_end <= 1'b1;
        endcase
        @(posedge ref_clk);
        line_cycle_end <= 1'b0;
        dsp_cycle_end  <= 1'b0;
        pulse_raw_n    <= 3'b111;
        @(posedge ref_clk);
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {nrst, line_cycle_end, dsp_cycle_end, current_peak_strobe, voltage_peak_strobe} = 5'h00;
        {current_peak_magnitude, voltage_peak_magnitude} = 48'h000000000000;
        {current_peak_phase_origin, voltage_peak_phase_origin, total_active_bit30} = 9'h000;
        {fund_active_bit30, total_reactive_bit30, fund_reactive_bit30, apparent_bit30} = 12'h000;
        {total_active_neg, fund_active_neg, total_reactive_neg, fund_reactive_neg} = 12'h000;
        sum_power_neg = 3'h0;
        pulse_raw_n   = 3'b111;
        {errors, checked, cycles} = 96'h0;
        repeat (4) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        chk_word({29'h00000000, pins}, 32'h00000007);
        rd_chk(CURRENT_PEAK_CAPTURE_OFS, 32'h00000000);
        rd_chk(VOLTAGE_PEAK_CAPTURE_OFS, 32'h00000000);
        rd_chk(EVENT_STATUS_FIRST_OFS, 32'h00000000);
        // line mode off: end of integration ignored
        host_model_i.wr(EVENT_CONTROL_OFS, 32'h00000038);
        apply(9, 0);
        rd_chk(EVENT_STATUS_FIRST_OFS, 32'h00000000);
        host_model_i.wr(EVENT_CONTROL_OFS, 32'h0000003C);
        rd_chk(EVENT_CONTROL_OFS, 32'h0000003C);
        for (int i = 0; i < 21; i++) begin
            apply(rows[i][0], rows[i][1]);
            if (rows[i][0] == 8) chk_bit(pins[rows[i][1]], 1'b1);
            rd_chk(EVENT_STATUS_FIRST_OFS, 32'h00000001 << rows[i][2]);
            host_model_i.wr(EVENT_STATUS_FIRST_OFS, 32'h00000001 << rows[i][2]);
            rd_chk(EVENT_STATUS_FIRST_OFS, 32'h00000000);
        end
        rd_chk(POWER_SIGN_REGISTER_OFS, 32'h000001FF);
        // enabled pulse pin follows raw one cycle later
        host_model_i.wr(EVENT_CONTROL_OFS, 32'h00000004);
        pulse_raw_n[1] <= 1'b0;
        @(posedge ref_clk);
        pulse_raw_n <= 3'b111;
        @(posedge ref_clk);
        chk_bit(pulse_out_two, 1'b0);
        @(posedge ref_clk);
        chk_bit(pulse_out_two, 1'b1);
        rd_chk(EVENT_STATUS_FIRST_OFS, 32'h00008000);
        // sticky across idle cycles, and a new event beats the clear
        apparent_bit30[0] <= ~apparent_bit30[0];
        repeat (6) @(posedge ref_clk);
        rd_chk(EVENT_STATUS_FIRST_OFS, 32'h00008010);
        {apparent_bit30[0], dsp_cycle_end} <= {~apparent_bit30[0], 1'b1};
        host_model_i.wr(EVENT_STATUS_FIRST_OFS, 32'hFFFFFFFF);
        dsp_cycle_end <= 1'b0;
        rd_chk(EVENT_STATUS_FIRST_OFS, 32'h00020010);
        // peak read right after its capture, then inputs move on; top bits stay zero
        {current_peak_strobe, current_peak_magnitude, current_peak_phase_origin} <= {1'b1, 24'hABCDEF, 3'b100};
        @(posedge ref_clk);
        {current_peak_strobe, current_peak_magnitude} <= {1'b0, 24'h123456};
        rd_chk(CURRENT_PEAK_CAPTURE_OFS, 32'h04ABCDEF);
        {voltage_peak_strobe, voltage_peak_magnitude, voltage_peak_phase_origin} <= {1'b1, 24'hFFFFFF, 3'b001};
        @(posedge ref_clk);
        {voltage_peak_strobe, voltage_peak_magnitude} <= {1'b0, 24'h123456};
        rd_chk(VOLTAGE_PEAK_CAPTURE_OFS, 32'h01FFFFFF);
        host_model_i.wr(CURRENT_PEAK_CAPTURE_OFS, 32'hFFFFFFFF);
        rd_chk(CURRENT_PEAK_CAPTURE_OFS, 32'h04ABCDEF);
        rd_chk(16'hE5FF, 32'h00000000);
        // both sign sources to fundamental: every selected sign turns positive
        host_model_i.wr(EVENT_CONTROL_OFS, 32'h00000007);
        rd_chk(EVENT_STATUS_FIRST_OFS, 32'h00021DD0);
        rd_chk(POWER_SIGN_REGISTER_OFS, 32'h00000188);
        // mid-run reset with nonzero levels: relearned, no false flags
        nrst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        nrst <= 1'b1;
        @(posedge ref_clk);
        rd_chk(EVENT_STATUS_FIRST_OFS, 32'h00000000);
        rd_chk(POWER_SIGN_REGISTER_OFS, 32'h000001FF);
        rd_chk(VOLTAGE_PEAK_CAPTURE_OFS, 32'h00000000);
        results();
    end
endmodule
